/* core/rpsm_defs.vh */
// Purpose: shared constants for the rmii pin strap mux
// Assumes: included by bare name from core files
// Notes:   definitions only
`ifndef RPSM_DEFS_VH
`define RPSM_DEFS_VH

// ************************************************
// register offsets (5-bit management address)
// ************************************************
`define RPSM_ADDR_W            5
`define RPSM_DATA_W            16
`define RPSM_OFS_INT_CTRL_STAT 5'h1B
`define RPSM_OFS_MISC_CTRL     5'h1F

// ************************************************
// field positions
// ************************************************
`define RPSM_INT_EN_LSB        8
`define RPSM_INT_EVT_W         8
`define RPSM_MISC_IRQ_POL_BIT  9

// ************************************************
// reset values
// ************************************************
`define RPSM_INT_EN_RST        8'h00
`define RPSM_INT_STAT_RST      8'h00
`define RPSM_MISC_CTRL_RST     16'h0000
`define RPSM_RDATA_RST         16'h0000

// ************************************************
// strap vector layout
// ************************************************
`define RPSM_STRAP_W           5
`define RPSM_STRAP_CFG2        0
`define RPSM_STRAP_BCAST_OFF   1
`define RPSM_STRAP_ISOLATE     2
`define RPSM_STRAP_NAND_TREE   3
`define RPSM_STRAP_WAKE_EN     4
`define RPSM_STRAP_RST         5'h00

`endif

/* core/rpsm_sync2.v */
// Purpose: two flip-flop synchroniser for a vector of levels
// Assumes: each bit is an independent level
// Notes:   no reset, so pin levels are already settled when reset lifts
`timescale 1ns/1ps
module rpsm_sync2 #(
    parameter W = 1
) (
    // clock
    input  wire         clk,
    // levels
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta;
    reg [W-1:0] stable;

    always @(posedge clk) begin
        meta   <= d;
        stable <= meta;
    end

    assign q = stable;
endmodule

/* core/rpsm_pin_mux.v */
// Purpose: dual-function rmii pins: strap capture at reset release, then rmii/irq function
// Assumes: clk 40 MHz, srst synchronous active high; core status inputs on clk
// Notes:   output enables are active low; pins are sampled through two flops
`timescale 1ns/1ps
`include "rpsm_defs.vh"
module rpsm_pin_mux (
    // clock and reset
    input  wire                        clk,
    input  wire                        srst,
    // mode selects
    input  wire                        clk_mode_50,
    input  wire                        wake_pin_sel,
    // core receive status and events
    input  wire                        crs_dv_core,
    input  wire                        rx_er_core,
    input  wire                        ref_clk_src,
    input  wire                        wake_event,
    input  wire [`RPSM_INT_EVT_W-1:0]  int_events,
    // management register port
    input  wire [`RPSM_ADDR_W-1:0]     reg_addr,
    input  wire                        reg_we,
    input  wire                        reg_re,
    input  wire [`RPSM_DATA_W-1:0]     reg_wdata,
    output reg  [`RPSM_DATA_W-1:0]     reg_rdata,
    // carrier sense / data valid pin
    input  wire                        crs_dv_pin_i,
    output reg                         crs_dv_pin_o,
    output reg                         crs_dv_pin_oe_n,
    // reference clock pin
    input  wire                        ref_clk_pin_i,
    output reg                         ref_clk_pin_o,
    output reg                         ref_clk_pin_oe_n,
    // receive error pin
    input  wire                        rx_er_pin_i,
    output reg                         rx_er_pin_o,
    output reg                         rx_er_pin_oe_n,
    // interrupt / wake option two pin
    input  wire                        irq_out_pin_i,
    output reg                         irq_out_pin_o,
    output reg                         irq_out_pin_oe_n,
    // wake-enable strap pin
    input  wire                        wake_en_pin_i,
    // mac transmit pins
    input  wire                        tx_en_pin,
    input  wire                        txd0_pin,
    input  wire                        txd1_pin,
    // transmit toward core
    output reg                         tx_en_core,
    output reg  [1:0]                  txd_core,
    // latched straps
    output reg                         strap_cfg_bit2,
    output reg                         broadcast_disable_strap,
    output reg                         isolate_strap,
    output reg                         nand_tree_strap,
    output reg                         wake_enable_strap
);

    // ************************************************
    // pin synchronisers
    // ************************************************
    wire [`RPSM_STRAP_W-1:0] strap_pins;
    wire [`RPSM_STRAP_W-1:0] strap_sync;
    wire [3:0]               tx_sync;

    assign strap_pins[`RPSM_STRAP_CFG2]      = crs_dv_pin_i;
    assign strap_pins[`RPSM_STRAP_BCAST_OFF] = ref_clk_pin_i;
    assign strap_pins[`RPSM_STRAP_ISOLATE]   = rx_er_pin_i;
    assign strap_pins[`RPSM_STRAP_NAND_TREE] = irq_out_pin_i;
    assign strap_pins[`RPSM_STRAP_WAKE_EN]   = wake_en_pin_i;

    rpsm_sync2 #(
        .W (`RPSM_STRAP_W)
    ) u_strap_sync (
        .clk (clk),
        .d   (strap_pins),
        .q   (strap_sync)
    );

    // ref_clk_src is a foreign clock, sampled like a pin
    rpsm_sync2 #(
        .W (4)
    ) u_tx_sync (
        .clk (clk),
        .d   ({ref_clk_src, txd1_pin, txd0_pin, tx_en_pin}),
        .q   (tx_sync)
    );

    // ************************************************
    // strap capture at reset release
    // ************************************************
    reg in_reset;

    always @(posedge clk) begin
        if (srst) begin
            in_reset <= 1'b1;
        end else begin
            in_reset <= 1'b0;
        end
    end

    wire release_edge = in_reset & ~srst;

    // captured once per release, then frozen until the next reset
    always @(posedge clk) begin
        if (release_edge) begin
            strap_cfg_bit2          <= strap_sync[`RPSM_STRAP_CFG2];
            broadcast_disable_strap <= strap_sync[`RPSM_STRAP_BCAST_OFF];
            isolate_strap           <= strap_sync[`RPSM_STRAP_ISOLATE];
            nand_tree_strap         <= strap_sync[`RPSM_STRAP_NAND_TREE];
            wake_enable_strap       <= strap_sync[`RPSM_STRAP_WAKE_EN];
        end else if (srst) begin
            strap_cfg_bit2          <= 1'b0;
            broadcast_disable_strap <= 1'b0;
            isolate_strap           <= 1'b0;
            nand_tree_strap         <= 1'b0;
            wake_enable_strap       <= 1'b0;
        end
    end

    // pins take their function only after capture; in_reset covers the release cycle
    wire func_on = ~srst & ~in_reset;

    // ************************************************
    // transmit inputs from the mac
    // ************************************************
    always @(posedge clk) begin
        if (srst) begin
            tx_en_core <= 1'b0;
            txd_core   <= 2'b00;
        end else begin
            tx_en_core <= tx_sync[0];
            txd_core   <= tx_sync[2:1];
        end
    end

    // ************************************************
    // management registers
    // ************************************************
    reg  [`RPSM_INT_EVT_W-1:0] int_en;
    reg  [`RPSM_INT_EVT_W-1:0] int_stat;
    reg  [`RPSM_DATA_W-1:0]    misc_ctrl;
    reg  [`RPSM_INT_EVT_W-1:0] next_int_stat;

    wire hit_int  = (reg_addr == `RPSM_OFS_INT_CTRL_STAT);
    wire hit_misc = (reg_addr == `RPSM_OFS_MISC_CTRL);
    wire irq_pol_high = misc_ctrl[`RPSM_MISC_IRQ_POL_BIT];

    // a new event in the read cycle survives the read-clear
    always @* begin
        next_int_stat = int_stat;
        if (reg_re && hit_int) begin
            next_int_stat = {`RPSM_INT_EVT_W{1'b0}};
        end
        next_int_stat = next_int_stat | int_events;
    end

    always @(posedge clk) begin
        if (srst) begin
            int_en    <= `RPSM_INT_EN_RST;
            int_stat  <= `RPSM_INT_STAT_RST;
            misc_ctrl <= `RPSM_MISC_CTRL_RST;
            reg_rdata <= `RPSM_RDATA_RST;
        end else begin
            int_stat <= next_int_stat;
            if (reg_we && hit_int) begin
                int_en <= reg_wdata[`RPSM_DATA_W-1:`RPSM_INT_EN_LSB];
            end
            if (reg_we && hit_misc) begin
                misc_ctrl <= reg_wdata;
            end
            if (reg_re) begin
                case (1'b1)
                    hit_int: begin
                        reg_rdata <= {int_en, int_stat};
                    end
                    hit_misc: begin
                        reg_rdata <= misc_ctrl;
                    end
                    default: begin
                        reg_rdata <= `RPSM_RDATA_RST;
                    end
                endcase
            end
        end
    end

    wire irq_active = |(int_stat & int_en);

    // ************************************************
    // pin drivers
    // ************************************************
    // registered so that pins never glitch from the selects
    always @(posedge clk) begin
        if (!func_on) begin
            crs_dv_pin_o     <= 1'b0;
            crs_dv_pin_oe_n  <= 1'b1;
            ref_clk_pin_o    <= 1'b0;
            ref_clk_pin_oe_n <= 1'b1;
            rx_er_pin_o      <= 1'b0;
            rx_er_pin_oe_n   <= 1'b1;
            irq_out_pin_o    <= 1'b0;
            irq_out_pin_oe_n <= 1'b1;
        end else begin
            crs_dv_pin_o     <= crs_dv_core;
            crs_dv_pin_oe_n  <= 1'b0;
            rx_er_pin_o      <= rx_er_core;
            rx_er_pin_oe_n   <= 1'b0;
            // 50 MHz mode relies on an external clock on crystal_in
            if (clk_mode_50) begin
                ref_clk_pin_o    <= 1'b0;
                ref_clk_pin_oe_n <= 1'b1;
            end else begin
                ref_clk_pin_o    <= tx_sync[3];
                ref_clk_pin_oe_n <= 1'b0;
            end
            irq_out_pin_o <= 1'b0;
            if (wake_pin_sel) begin
                // open drain: pull low only while the wake event stands
                irq_out_pin_oe_n <= ~wake_event;
            end else if (irq_pol_high) begin
                // active high needs the pin driven both ways
                irq_out_pin_o    <= irq_active;
                irq_out_pin_oe_n <= 1'b0;
            end else begin
                irq_out_pin_oe_n <= ~irq_active;
            end
        end
    end

endmodule

/* bench/rpsm_mac_model.sv */
// Purpose: mac transmit side model for rpsm_pin_mux
// Assumes: clocked by whichever rmii reference clock is live
// Notes:   idle data lines invert so stale values never pass
`timescale 1ns/1ps
module rpsm_mac_model (
    // reference clock and request
    input  wire ref_clk,
    input  wire send,
    // transmit pins
    output reg  tx_en,
    output reg  txd0,
    output reg  txd1
);
    initial {tx_en, txd1, txd0} = 3'h0;
    always @(posedge ref_clk) begin
        tx_en <= send;
        {txd1, txd0} <= send ? {txd1, txd0} + 2'h1 : ~{txd1, txd0};
    end
endmodule

/* bench/rpsm_pin_mux_chk.sv */
// Purpose: port checks for rpsm_pin_mux
// Assumes: pins steady around reset release
// Notes:   bound into every rpsm_pin_mux
`timescale 1ns/1ps
module rpsm_pin_mux_chk (
    // clock, reset and selects
    input wire       clk,
    input wire       srst,
    input wire       clk_mode_50,
    input wire       wake_pin_sel,
    // core side
    input wire       crs_dv_core,
    input wire       rx_er_core,
    input wire       ref_clk_src,
    input wire       wake_event,
    // shared pins
    input wire       crs_dv_pin_i,
    input wire       crs_dv_pin_o,
    input wire       crs_dv_pin_oe_n,
    input wire       ref_clk_pin_i,
    input wire       ref_clk_pin_o,
    input wire       ref_clk_pin_oe_n,
    input wire       rx_er_pin_i,
    input wire       rx_er_pin_o,
    input wire       rx_er_pin_oe_n,
    input wire       irq_out_pin_i,
    input wire       irq_out_pin_o,
    input wire       irq_out_pin_oe_n,
    input wire       wake_en_pin_i,
    // transmit path
    input wire       tx_en_pin,
    input wire       txd0_pin,
    input wire       txd1_pin,
    input wire       tx_en_core,
    input wire [1:0] txd_core,
    // straps
    input wire       strap_cfg_bit2,
    input wire       broadcast_disable_strap,
    input wire       isolate_strap,
    input wire       nand_tree_strap,
    input wire       wake_enable_strap
);
    // *****
    // checks
    // *****
    wire [4:0] st = {wake_enable_strap, nand_tree_strap, isolate_strap, broadcast_disable_strap, strap_cfg_bit2};
    wire [3:0] pi = {wake_en_pin_i, irq_out_pin_i, rx_er_pin_i, ref_clk_pin_i};
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    property p_rst_oe;
        disable iff (1'b0)
        srst |=> crs_dv_pin_oe_n && ref_clk_pin_oe_n && rx_er_pin_oe_n && irq_out_pin_oe_n;
    endproperty
    a_rst_oe: assert property (p_rst_oe) else $error("pin driven in reset");
    // capture at release uses the pin level three samples back, through the sync pair
    property p_cfg2;
        $past(srst) |=> strap_cfg_bit2 == $past(crs_dv_pin_i, 3);
    endproperty
    a_cfg2: assert property (p_cfg2) else $error("config bit two strap wrong");
    property p_straps;
        $past(srst) |=> st[4:1] == $past(pi, 3);
    endproperty
    a_straps: assert property (p_straps) else $error("strap capture wrong");
    property p_hold;
        !$past(srst) && !$past(srst, 2) |-> $stable(st);
    endproperty
    a_hold: assert property (p_hold) else $error("strap changed");
    property p_rx;
        !$past(srst) |=> !crs_dv_pin_oe_n && !rx_er_pin_oe_n
            && crs_dv_pin_o == $past(crs_dv_core) && rx_er_pin_o == $past(rx_er_core);
    endproperty
    a_rx: assert property (p_rx) else $error("receive status pins wrong");
    property p_ref_off;
        $past(clk_mode_50) |-> ref_clk_pin_oe_n;
    endproperty
    a_ref_off: assert property (p_ref_off) else $error("ref clock driven in 50 MHz mode");
    property p_ref_on;
        !clk_mode_50 && !$past(clk_mode_50) && !$past(srst) && !$past(srst, 2)
            |-> !ref_clk_pin_oe_n && ref_clk_pin_o == $past(ref_clk_src, 3);
    endproperty
    a_ref_on: assert property (p_ref_on) else $error("ref clock output wrong");
    property p_tx;
        !$past(srst) |-> tx_en_core == $past(tx_en_pin, 3)
            && txd_core == {$past(txd1_pin, 3), $past(txd0_pin, 3)};
    endproperty
    a_tx: assert property (p_tx) else $error("transmit path wrong");
    // wake option only ever pulls low, one cycle behind the event level
    property p_wake;
        $past(wake_pin_sel) && !$past(srst) && !$past(srst, 2)
            |-> irq_out_pin_oe_n == !$past(wake_event) && !irq_out_pin_o;
    endproperty
    a_wake: assert property (p_wake) else $error("wake output pin wrong");
endmodule
bind rpsm_pin_mux rpsm_pin_mux_chk i_rpsm_pin_mux_chk (.*);

/* bench/rpsm_pin_mux_tb.sv */
// Purpose: directed bench for rpsm_pin_mux
// Assumes: board pulls modelled by pull vector
// Notes:   inputs change 2 ns after the rising edge
`timescale 1ns/1ps
module rpsm_pin_mux_tb;
    reg clk = 1'b0, srst = 1'b1, clk_mode_50 = 1'b0, wake_pin_sel = 1'b0, crs_dv_core = 1'b0, rx_er_core = 1'b0;
    reg ref_clk_src = 1'b0, wake_event = 1'b0, reg_we = 1'b0, reg_re = 1'b0, send = 1'b0;
    reg [7:0] int_events = 8'h00;
    reg [4:0] reg_addr = 5'h00, pull = 5'h00;
    reg [15:0] reg_wdata = 16'h0000;
    wire [15:0] reg_rdata;
    wire crs_o, crs_oe_n, ref_o, ref_oe_n, rxe_o, rxe_oe_n, irq_o, irq_oe_n, tx_en, txd0, txd1, tx_en_core;
    wire [1:0] txd_core;
    wire [4:0] st;
    integer mismatches = 0, n_checks = 0;
    // released pins settle to their board pulls
    wire crs_pin = crs_oe_n ? pull[0] : crs_o;
    wire ref_pin = ref_oe_n ? pull[1] : ref_o;
    wire rxe_pin = rxe_oe_n ? pull[2] : rxe_o;
    wire irq_pin = irq_oe_n ? pull[3] : irq_o;
    rpsm_pin_mux i_rpsm_pin_mux (.clk(clk), .srst(srst), .clk_mode_50(clk_mode_50), .wake_pin_sel(wake_pin_sel),
        .crs_dv_core(crs_dv_core), .rx_er_core(rx_er_core), .ref_clk_src(ref_clk_src), .wake_event(wake_event),
        .int_events(int_events), .reg_addr(reg_addr), .reg_we(reg_we), .reg_re(reg_re), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .crs_dv_pin_i(crs_pin), .crs_dv_pin_o(crs_o), .crs_dv_pin_oe_n(crs_oe_n),
        .ref_clk_pin_i(ref_pin), .ref_clk_pin_o(ref_o), .ref_clk_pin_oe_n(ref_oe_n), .rx_er_pin_i(rxe_pin),
        .rx_er_pin_o(rxe_o), .rx_er_pin_oe_n(rxe_oe_n), .irq_out_pin_i(irq_pin), .irq_out_pin_o(irq_o),
        .irq_out_pin_oe_n(irq_oe_n), .wake_en_pin_i(pull[4]), .tx_en_pin(tx_en), .txd0_pin(txd0),
        .txd1_pin(txd1), .tx_en_core(tx_en_core), .txd_core(txd_core), .strap_cfg_bit2(st[0]),
        .broadcast_disable_strap(st[1]), .isolate_strap(st[2]), .nand_tree_strap(st[3]), .wake_enable_strap(st[4]));
    rpsm_mac_model i_rpsm_mac_model (.ref_clk(clk_mode_50 ? ref_clk_src : ref_pin), .send(send),
        .tx_en(tx_en), .txd0(txd0), .txd1(txd1));
    initial forever #12.5 clk = ~clk;
    initial forever #100 ref_clk_src = ~ref_clk_src;
    initial begin
        #100000;
        mismatches = mismatches + 1;
        final_report;
    end
    // *****
    // tasks
    // *****
    task cyc(input integer n);
        begin
            repeat (n) @(posedge clk);
            #2;
        end
    endtask
    task chk(input [8*6-1:0] nm, input [15:0] e, input [15:0] g);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("Error %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task wr(input [4:0] a, input [15:0] d);
        begin
            reg_addr = a;
            reg_wdata = d;
            reg_we = 1'b1;
            cyc(1);
            reg_we = 1'b0;
            cyc(1);
        end
    endtask
    task rd(input [4:0] a, input [15:0] e);
        begin
            reg_addr = a;
            reg_re = 1'b1;
            cyc(1);
            reg_re = 1'b0;
            chk("rdata", e, reg_rdata);
            cyc(1);
        end
    endtask
    // strap pulls swap after release; captured values must not follow
    task rst(input [4:0] p);
        begin
            pull = p;
            srst = 1'b1;
            cyc(20);
            srst = 1'b0;
            cyc(3);
            chk("straps", {11'h000, p}, {11'h000, st});
            pull = ~p;
            cyc(4);
            chk("straps", {11'h000, p}, {11'h000, st});
            pull = p;
        end
    endtask
    task evt(input [7:0] e, input [15:0] pin);
        begin
            int_events = e;
            cyc(1);
            int_events = 8'h00;
            cyc(2);
            chk("irq", pin, {15'h0000, irq_pin});
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", n_checks, mismatches);
            if (mismatches == 0 && n_checks > 0) begin
                $display("Testbench passed");
            end else begin
                $display("Testbench failed");
            end
            $finish;
        end
    endtask
    initial begin
        rst(5'h15);
        rst(5'h0A);
        send = 1'b1;
        crs_dv_core = 1'b1;
        rd(5'h1B, 16'h0000);
        wr(5'h1B, 16'hFFFF);
        rx_er_core = 1'b1;
        rd(5'h1B, 16'hFF00);
        wr(5'h1F, 16'hA5C3);
        crs_dv_core = 1'b0;
        rd(5'h1F, 16'hA5C3);
        wr(5'h05, 16'h1234);
        rd(5'h05, 16'h0000);
        evt(8'h08, 16'h0000);
        rd(5'h1B, 16'hFF08);
        cyc(2);
        chk("irq", 16'h0001, {15'h0000, irq_pin});
        wr(5'h1B, 16'h0000);
        evt(8'h80, 16'h0001);
        rd(5'h1B, 16'h0080);
        wr(5'h1B, 16'hFF00);
        wr(5'h1F, 16'h0200);
        evt(8'h01, 16'h0001);
        chk("irqoe", 16'h0000, {15'h0000, irq_oe_n});
        rd(5'h1B, 16'hFF01);
        cyc(2);
        chk("irq", 16'h0000, {15'h0000, irq_pin});
        wake_pin_sel = 1'b1;
        wake_event = 1'b1;
        cyc(2);
        chk("wake", 16'h0000, {15'h0000, irq_pin});
        wake_event = 1'b0;
        cyc(2);
        chk("wake", 16'h0001, {15'h0000, irq_pin});
        clk_mode_50 = 1'b1;
        cyc(2);
        chk("refoe", 16'h0001, {15'h0000, ref_oe_n});
        cyc(40);
        clk_mode_50 = 1'b0;
        cyc(4);
        chk("refoe", 16'h0000, {15'h0000, ref_oe_n});
        send = 1'b0;
        cyc(10);
        final_report;
    end
endmodule
